// file: logic/adc_pipe_pkg.sv
// Package for the sample output pipeline of a 10-bit sampling converter.
// Assumes one system clock at 100 MHz; the conversion clock arrives as a synchronous input.
package adc_pipe_pkg;

  localparam int unsigned CODE_W         = 10;
  localparam int unsigned PIPE_DEPTH     = 2;
  localparam logic [9:0]  CODE_ZERO      = 10'h000;
  localparam logic [9:0]  CODE_FULL      = 10'h3FF;
  localparam int unsigned SYS_CLK_MHZ    = 100;
  localparam int unsigned WAKE_NS        = 700;
  localparam int unsigned WAKE_CYCLES    = (WAKE_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam int unsigned WAKE_W         = 7;
  localparam logic [6:0]  WAKE_LOAD      = 7'(WAKE_CYCLES);
  localparam logic [6:0]  WAKE_ZERO      = 7'h00;
  localparam logic [6:0]  WAKE_ONE       = 7'h01;

  typedef enum logic [1:0] {
    ST_RUN   = 2'b01,
    ST_SLEEP = 2'b10
  } pwr_state_t;

endpackage : adc_pipe_pkg

// file: logic/adc_pipe_stage.sv
// One pipeline register stage for converted codes.
// Assumes an advance enable that pulses once per conversion clock fall.
`timescale 1ns/1ps
module adc_pipe_stage
  import adc_pipe_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              rst,
  input  wire logic              advance,
  input  wire logic [CODE_W-1:0] code_in,
  output logic      [CODE_W-1:0] code_out
);

  typedef struct packed {
    logic [CODE_W-1:0] code;
  } stage_state_t;

  stage_state_t s_q;
  stage_state_t s_d;

  always_comb begin
    s_d = s_q;
    if (advance) begin
      s_d.code = code_in;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_q.code <= CODE_ZERO;
    end else begin
      s_q <= s_d;
    end
  end

  assign code_out = s_q.code;

endmodule : adc_pipe_stage

// file: logic/adc_sample_output_pipeline.sv
// Digital side of a 10-bit sampling converter: sample, two-stage pipeline, output drivers.
// Assumes conv_clk, power_down_pin and oe_n are synchronous to sys_clk, and that the
// analog front end delivers a raw code with under- and over-range flags.
`timescale 1ns/1ps

module adc_sample_output_pipeline
  import adc_pipe_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              rst,
  input  wire logic              conv_clk,
  input  wire logic              power_down_pin,
  input  wire logic              oe_n,
  input  wire logic [CODE_W-1:0] analog_input,
  input  wire logic              below_range,
  input  wire logic              above_range,
  output logic      [CODE_W-1:0] data_out,
  output logic      [CODE_W-1:0] data_oe_n,
  output logic                   data_valid,
  output logic                   wake_settled
);

  // ===========================================================================
  // State
  // ===========================================================================
  typedef struct packed {
    logic              clk_prev;
    pwr_state_t        pwr;
    logic [CODE_W-1:0] sample;
    logic [1:0]        fill;
    logic [CODE_W-1:0] out;
    logic [WAKE_W-1:0] wake_cnt;
  } top_state_t;

  top_state_t s_q;
  top_state_t s_d;

  logic              fall;
  logic              advance;
  logic [CODE_W-1:0] clamped;
  logic [CODE_W-1:0] stage_code;

  // ===========================================================================
  // Sampling and clamping
  // ===========================================================================
  assign fall    = s_q.clk_prev & ~conv_clk;
  assign advance = fall & (s_q.pwr == ST_RUN);

  always_comb begin
    if (below_range) begin
      clamped = CODE_ZERO;
    end else if (above_range) begin
      clamped = CODE_FULL;
    end else begin
      clamped = analog_input;
    end
  end

  // The sample register is the first of two pipeline stages; the second is the
  // stage module, whose output is copied into the output register on the fall.
  adc_pipe_stage u_stage (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .advance  (advance),
    .code_in  (s_q.sample),
    .code_out (stage_code)
  );

  // ===========================================================================
  // Next state
  // ===========================================================================
  always_comb begin
    s_d          = s_q;
    s_d.clk_prev = conv_clk;
    case (s_q.pwr)
      ST_RUN: begin
        if (power_down_pin) begin
          s_d.pwr  = ST_SLEEP;
          s_d.fill = 2'b00;
        end
      end
      ST_SLEEP: begin
        if (!power_down_pin) begin
          s_d.pwr      = ST_RUN;
          s_d.wake_cnt = WAKE_LOAD;
        end
      end
      default: begin
        s_d.pwr = ST_SLEEP;
      end
    endcase
    if (advance) begin
      s_d.sample = clamped;
      s_d.out    = stage_code;
      if (s_q.fill != 2'(PIPE_DEPTH)) begin
        s_d.fill = s_q.fill + 2'b01;
      end
    end
    if (s_q.pwr == ST_RUN && s_q.wake_cnt != WAKE_ZERO) begin
      s_d.wake_cnt = s_q.wake_cnt - WAKE_ONE;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_q.clk_prev <= 1'b0;
      s_q.pwr      <= ST_SLEEP;
      s_q.sample   <= CODE_ZERO;
      s_q.fill     <= 2'b00;
      s_q.out      <= CODE_ZERO;
      s_q.wake_cnt <= WAKE_ZERO;
    end else begin
      s_q <= s_d;
    end
  end

  // ===========================================================================
  // Outputs
  // ===========================================================================
  logic drive;
  assign drive      = ~oe_n & ~power_down_pin;
  assign data_out   = s_q.out;
  assign data_oe_n  = {CODE_W{~drive}};
  assign data_valid = (s_q.pwr == ST_RUN) && (s_q.fill == 2'(PIPE_DEPTH));
  assign wake_settled = (s_q.pwr == ST_RUN) && (s_q.wake_cnt == WAKE_ZERO);

endmodule : adc_sample_output_pipeline

// file: verif/adc_capture_model.sv
// Capture model: takes each driven word two clocks after a fall, once wake_settled is high.
// Expects conv_clk synchronous to sys_clk.
`timescale 1ns/1ps
module adc_capture_model
  import adc_pipe_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       conv_clk,
  input  wire logic       wake_settled,
  input  wire logic [9:0] data_out,
  input  wire logic [9:0] data_oe_n,
  output logic      [9:0] word_q
);
  // ==
  // Capture
  logic [2:0] h_q;
  always_ff @(posedge sys_clk) begin
    h_q <= {h_q[1:0], conv_clk};
    if (h_q[2:1] == 2'b10 && wake_settled && !data_oe_n) word_q <= data_out;
  end
endmodule : adc_capture_model

// file: verif/adc_pipe_chk.sv
// Port checker for the converter pipeline.
// Bound to the top module at the foot.
`timescale 1ns/1ps
module adc_pipe_chk
  import adc_pipe_pkg::*;
(
  input wire logic       sys_clk,
  input wire logic       rst,
  input wire logic       conv_clk,
  input wire logic       power_down_pin,
  input wire logic       oe_n,
  input wire logic [9:0] data_out,
  input wire logic [9:0] data_oe_n,
  input wire logic       data_valid,
  input wire logic       wake_settled
);
  // ==
  // Checks
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_oe_map: assert property (data_oe_n == {10{oe_n | power_down_pin}}) else $error("oe");
  a_pd_float: assert property (power_down_pin |-> &data_oe_n) else $error("pd");
  a_out_hold:
    assert property ($changed(data_out) |-> !$past(conv_clk) && $past(conv_clk, 2))
    else $error("ho");
  a_sleep_hold:
    assert property ($past(power_down_pin) && power_down_pin |=> $stable(data_out))
    else $error("sh");
  a_sleep_empty: assert property (power_down_pin |=> !data_valid) else $error("se");
  a_fill_keep:
    assert property (data_valid && !power_down_pin |=> data_valid) else $error("fk");
  a_wake_run:
    assert property (wake_settled |-> !$past(power_down_pin, 8)) else $error("wr");
  a_wake_delay:
    assert property ($fell(power_down_pin) |-> !wake_settled [*8]) else $error("wd");
endmodule : adc_pipe_chk
bind adc_sample_output_pipeline adc_pipe_chk chk (.*);

// file: verif/adc_sample_output_pipeline_tb_top.sv
// Bench for the converter pipeline.
// Uses the checker and capture model.
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin mismatches++; \
  $display("[ERR] %s exp %h got %h", n, e, g); end end
module adc_sample_output_pipeline_tb_top
  import adc_pipe_pkg::*;
;
  logic       sys_clk = 0, rst = 1, conv_clk = 0, power_down_pin = 0, oe_n = 0;
  logic       below_range = 0, above_range = 0, data_valid, wake_settled;
  logic [9:0] analog_input = '0, data_out, data_oe_n, word_q, hist[$];
  int         mismatches = 0, checks = 0;
  adc_sample_output_pipeline dut (.*);
  adc_capture_model cap (.*);
  // ==
  // Scenarios
  initial forever #5 sys_clk = ~sys_clk;
  task results;
    if (mismatches == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : results
  task step(input logic [9:0] v, input logic b, a);
    @(posedge sys_clk) {analog_input, below_range, above_range, conv_clk} <= {v, b, a, 1'b1};
    repeat (3) @(posedge sys_clk) conv_clk <= 0;
    #1 hist.push_back(b ? CODE_ZERO : a ? CODE_FULL : v);
    if (hist.size() > 2) `CHK("out", hist[hist.size() - 3], data_out)
  endtask : step
  task t_pipe;
    int n;
    hist.delete();
    n = 0;
    while (!wake_settled && n < 90) begin
      @(posedge sys_clk) #1;
      n++;
    end
    `CHK("wake", WAKE_CYCLES + 1, n)
    for (int i = 0; i < 14; i++)
      step(10'h3FF - 10'(i) * 10'h05D, i inside {6, 8}, i inside {7, 8});
    `CHK("valid", 1'b1, data_valid)
    @(posedge sys_clk);
    #1 `CHK("word", hist[hist.size() - 3], word_q)
  endtask : t_pipe
  task t_oe;
    @(posedge sys_clk) oe_n <= 1;
    #1 `CHK("oe", CODE_FULL, data_oe_n)
    @(posedge sys_clk) {oe_n, power_down_pin} <= 2'b01;
    #1 `CHK("oe", CODE_FULL, data_oe_n)
    repeat (6) @(posedge sys_clk) conv_clk <= ~conv_clk;
    #1 `CHK("out", hist[hist.size() - 3], data_out)
    @(posedge sys_clk) power_down_pin <= 0;
  endtask : t_oe
  initial begin
    repeat (2) @(posedge sys_clk);
    rst <= 0;
    t_pipe;
    t_oe;
    t_pipe;
    results;
  end
  initial begin
    #20000;
    mismatches++;
    results;
  end
endmodule : adc_sample_output_pipeline_tb_top
